// ===== pwr_seq_cfg.svh
`ifndef PWR_SEQ_CFG_SVH
`define PWR_SEQ_CFG_SVH

// Host command register offsets (APB byte addresses)
`define PSQ_CTRL_OFS 12'h000
`define PSQ_DSPCTL_OFS 12'h004
`define PSQ_STATUS_OFS 12'h008

// Low-power control register field positions
`define PSQ_LV_EN_BIT 0
`define PSQ_DEEP_EN_BIT 4
`define PSQ_OSC_CTL_BIT 9
`define PSQ_ISO_BIT 12

// DSP control register field positions
`define PSQ_DSP_EN_BIT 0
`define PSQ_DSP_RST_BIT 1
`define PSQ_DSP_CKEN_BIT 2
`define PSQ_SUPPLY_BIT 3

// Reset values
`define PSQ_CTRL_RST 32'h0000_0000
`define PSQ_DSPCTL_RST 32'h0000_0003

// Supply ramp and settle wait in the device, in ns and in clock cycles
`define PSQ_SETTLE_NS 500
`define PSQ_CLK_NS 50
`define PSQ_SETTLE_CYC ((`PSQ_SETTLE_NS + `PSQ_CLK_NS - 1) / `PSQ_CLK_NS)

`endif

// ===== pwr_seq_pkg.sv
package pwr_seq_pkg;
  typedef enum logic [1:0] {
    DOM_ACTIVE,
    DOM_INACTIVE,
    DOM_PENDING,
    DOM_SLEEP
  } dom_state_t;

  typedef enum logic [1:0] {
    LPC_AWAKE,
    LPC_BIG_SLEEP,
    LPC_DEEP_SLEEP,
    LPC_OFF
  } lpc_state_t;

  // Chip state codes: 0 off, 1.x=1..3, 2.x=4..5, 3.x=6..7
  typedef enum logic [2:0] {
    CHIP_OFF,
    CHIP_1_1,
    CHIP_1_2,
    CHIP_1_3,
    CHIP_2_1,
    CHIP_2_2,
    CHIP_3_1,
    CHIP_3_2
  } chip_state_t;
endpackage

// ===== pwr_seq_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pwr_seq_if;
  logic host_irq;
  logic dsp_irq;
  logic ext_clk_req;
  logic host_standby;
  logic dsp_idle_exec;
  logic lv_en;
  logic deep_en;
  logic osc_ctl;
  logic iso_ctl;
  logic dsp_en;
  logic dsp_rst;
  logic dsp_input_clock_en;
  logic supply_on;
  logic pwr_good;
  logic proc_clk_en;
  logic dsp_clk_on;
  logic dsp_reset;
  logic dsp_iso;
  logic chip_wake;
  logic low_voltage_request;
  logic osc_stop;
  logic dsp_idle;
  logic [1:0] host_state;
  logic [1:0] dsp_state;
  logic [2:0] chip_state;

  modport dev (
    input host_irq, dsp_irq, ext_clk_req, host_standby, dsp_idle_exec,
    input lv_en, deep_en, osc_ctl, iso_ctl, dsp_en, dsp_rst, dsp_input_clock_en,
    input pwr_good,
    output proc_clk_en, dsp_clk_on, dsp_reset, dsp_iso, chip_wake,
    output low_voltage_request, osc_stop, dsp_idle, host_state,
    output dsp_state, chip_state
  );
  modport host (
    output lv_en, deep_en, osc_ctl, iso_ctl, dsp_en, dsp_rst, dsp_input_clock_en,
    output supply_on, host_standby,
    input proc_clk_en, dsp_clk_on, dsp_reset, dsp_iso, chip_wake,
    input low_voltage_request, osc_stop, dsp_idle, host_state,
    input dsp_state, chip_state
  );
endinterface
`default_nettype wire

// ===== pwr_seq_dev.sv
//Contract
//- Chip state from host and DSP states
//- Host states map to controller states
//- State held except in sleep
//- DSP sleep: reset, isolation, clocks off
//- DSP pending only if already inactive
//- Unmasked interrupt restarts inactive DSP clocks
//- DSP idle instruction gates DSP clock
//- Readable DSP idle status flag
//- Software sleep order for DSP
//- Software wake order for DSP
//- No interrupt wake from DSP sleep
//- Unmasked interrupts raise wake request (here the DSP interrupt counts only while the DSP is inactive or pending)
//- Wake request restores awake and clock
//- Software prepares host before idling
//- Clear deep bit for big sleep
//- Standby shuts clocks, then chip idle
//- Chip idle: clock off, wake asserted
//- Set deep, low-voltage, oscillator bits
//- Only DSP idle self-initiated
//- DSP software gates clocks before idle
//- Hardware steps by controller state machine
//- Isolation bit cleared at power-up only
//- Low-voltage output high in deep sleep
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pwr_seq_cfg.svh"
module pwr_seq_dev (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_host_irq,
  input wire logic i_dsp_irq,
  input wire logic i_ext_clk_req,
  input wire logic i_dsp_idle_exec,
  input wire logic i_host_standby,
  pwr_seq_if.dev bus
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic host_irq_s, dsp_irq_s, ext_req_s, dsp_idle_s, standby_s;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
    end else begin
      sync1_reg <= {i_host_standby, i_dsp_idle_exec, i_ext_clk_req,
                    i_dsp_irq, i_host_irq};
      sync2_reg <= sync1_reg;
    end
  end
  assign host_irq_s = sync2_reg[0];
  assign dsp_irq_s = sync2_reg[1];
  assign ext_req_s = sync2_reg[2];
  assign dsp_idle_s = sync2_reg[3];
  assign standby_s = sync2_reg[4];

  // ****************************************
  // Wake request
  // ****************************************
  pwr_seq_pkg::dom_state_t host_reg;
  pwr_seq_pkg::dom_state_t dsp_reg;
  logic wake_request;

  always_comb begin
    wake_request = host_irq_s;
    // Sleeping DSP has no wake path
    if (dsp_reg == pwr_seq_pkg::DOM_INACTIVE ||
        dsp_reg == pwr_seq_pkg::DOM_PENDING) begin
      wake_request = host_irq_s | dsp_irq_s;
    end
  end

  // ****************************************
  // Clock/reset unit: standby shutdown sequence
  // ****************************************
  typedef enum logic [1:0] {
    CRU_RUN,
    CRU_GATE,
    CRU_PLL_IDLE,
    CRU_IDLE
  } cru_t;
  cru_t cru_reg;
  logic chip_idle;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cru_reg <= CRU_RUN;
    end else begin
      case (cru_reg)
        CRU_RUN: if (standby_s && host_reg == pwr_seq_pkg::DOM_ACTIVE &&
                     !wake_request) cru_reg <= CRU_GATE;
        CRU_GATE: cru_reg <= CRU_PLL_IDLE;
        CRU_PLL_IDLE: cru_reg <= CRU_IDLE;
        CRU_IDLE: if (host_reg != pwr_seq_pkg::DOM_ACTIVE)
          cru_reg <= CRU_RUN;
        default: cru_reg <= CRU_RUN;
      endcase
    end
  end
  assign chip_idle = (cru_reg == CRU_IDLE);

  // ****************************************
  // Low-power controller state machine
  // ****************************************
  pwr_seq_pkg::lpc_state_t lpc_reg;
  logic [7:0] settle_cnt_reg;
  logic proc_clk_reg, chip_wake_reg, lv_reg, osc_stop_reg;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lpc_reg <= pwr_seq_pkg::LPC_AWAKE;
      settle_cnt_reg <= 8'h00;
    end else begin
      case (lpc_reg)
        pwr_seq_pkg::LPC_AWAKE: begin
          if (chip_idle) begin
            lpc_reg <= bus.deep_en ? pwr_seq_pkg::LPC_DEEP_SLEEP
                                   : pwr_seq_pkg::LPC_BIG_SLEEP;
          end
        end
        pwr_seq_pkg::LPC_BIG_SLEEP: begin
          if (wake_request || ext_req_s) lpc_reg <= pwr_seq_pkg::LPC_AWAKE;
        end
        pwr_seq_pkg::LPC_DEEP_SLEEP: begin
          // Supplies must settle before the clock is given back
          if (settle_cnt_reg != 8'h00) begin
            settle_cnt_reg <= settle_cnt_reg - 8'h01;
            if (settle_cnt_reg == 8'h01) lpc_reg <= pwr_seq_pkg::LPC_AWAKE;
          end else if (wake_request || ext_req_s) begin
            settle_cnt_reg <= 8'(`PSQ_SETTLE_CYC);
          end
        end
        default: lpc_reg <= pwr_seq_pkg::LPC_AWAKE;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      proc_clk_reg <= 1'b1;
      chip_wake_reg <= 1'b0;
    end else begin
      proc_clk_reg <= (lpc_reg == pwr_seq_pkg::LPC_AWAKE) && !chip_idle;
      chip_wake_reg <= (lpc_reg != pwr_seq_pkg::LPC_AWAKE) || chip_idle;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lv_reg <= 1'b0;
      osc_stop_reg <= 1'b0;
    end else begin
      lv_reg <= bus.lv_en && lpc_reg == pwr_seq_pkg::LPC_DEEP_SLEEP &&
                settle_cnt_reg == 8'h00;
      osc_stop_reg <= bus.osc_ctl &&
                      lpc_reg == pwr_seq_pkg::LPC_DEEP_SLEEP;
    end
  end

  // ****************************************
  // Domain state tracking
  // ****************************************
  always_comb begin
    case (lpc_reg)
      pwr_seq_pkg::LPC_AWAKE: host_reg = pwr_seq_pkg::DOM_ACTIVE;
      pwr_seq_pkg::LPC_BIG_SLEEP: host_reg = pwr_seq_pkg::DOM_INACTIVE;
      pwr_seq_pkg::LPC_DEEP_SLEEP: host_reg = pwr_seq_pkg::DOM_PENDING;
      default: host_reg = pwr_seq_pkg::DOM_SLEEP;
    endcase
  end

  // Pending is granted only at the first edge after the host enters it
  logic host_pend_reg;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      host_pend_reg <= 1'b0;
    end else begin
      host_pend_reg <= (host_reg == pwr_seq_pkg::DOM_PENDING);
    end
  end

  logic dsp_idle_reg;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dsp_reg <= pwr_seq_pkg::DOM_SLEEP;
      dsp_idle_reg <= 1'b0;
    end else if (!bus.pwr_good || (bus.dsp_rst && bus.iso_ctl)) begin
      dsp_reg <= pwr_seq_pkg::DOM_SLEEP;
      dsp_idle_reg <= 1'b0;
    end else begin
      case (dsp_reg)
        pwr_seq_pkg::DOM_SLEEP: // Only software leaves sleep
          if (!bus.iso_ctl && bus.dsp_input_clock_en && !bus.dsp_rst &&
              !bus.dsp_en) dsp_reg <= pwr_seq_pkg::DOM_ACTIVE;
        pwr_seq_pkg::DOM_ACTIVE:
          if (dsp_idle_s) begin
            dsp_reg <= pwr_seq_pkg::DOM_INACTIVE;
            dsp_idle_reg <= 1'b1;
          end
        pwr_seq_pkg::DOM_INACTIVE:
          if (dsp_irq_s && !bus.dsp_rst) begin
            dsp_reg <= pwr_seq_pkg::DOM_ACTIVE;
            dsp_idle_reg <= 1'b0;
          end else if (host_reg == pwr_seq_pkg::DOM_PENDING &&
                       !host_pend_reg) begin
            dsp_reg <= pwr_seq_pkg::DOM_PENDING;
          end
        pwr_seq_pkg::DOM_PENDING:
          if (host_reg != pwr_seq_pkg::DOM_PENDING) begin
            dsp_reg <= pwr_seq_pkg::DOM_INACTIVE;
          end
        default: dsp_reg <= pwr_seq_pkg::DOM_SLEEP;
      endcase
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  pwr_seq_pkg::chip_state_t chip_reg;
  always_comb begin
    chip_reg = pwr_seq_pkg::CHIP_OFF;
    case (host_reg)
      pwr_seq_pkg::DOM_ACTIVE:
        case (dsp_reg)
          pwr_seq_pkg::DOM_SLEEP: chip_reg = pwr_seq_pkg::CHIP_1_3;
          pwr_seq_pkg::DOM_ACTIVE: chip_reg = pwr_seq_pkg::CHIP_1_1;
          default: chip_reg = pwr_seq_pkg::CHIP_1_2;
        endcase
      pwr_seq_pkg::DOM_INACTIVE:
        chip_reg = (dsp_reg == pwr_seq_pkg::DOM_SLEEP) ?
                   pwr_seq_pkg::CHIP_2_2 : pwr_seq_pkg::CHIP_2_1;
      pwr_seq_pkg::DOM_PENDING:
        chip_reg = (dsp_reg == pwr_seq_pkg::DOM_SLEEP) ?
                   pwr_seq_pkg::CHIP_3_2 : pwr_seq_pkg::CHIP_3_1;
      default: chip_reg = pwr_seq_pkg::CHIP_OFF;
    endcase
  end

  assign bus.proc_clk_en = proc_clk_reg;
  assign bus.chip_wake = chip_wake_reg;
  assign bus.low_voltage_request = lv_reg;
  assign bus.osc_stop = osc_stop_reg;
  assign bus.dsp_clk_on = (dsp_reg == pwr_seq_pkg::DOM_ACTIVE) &&
                          bus.dsp_input_clock_en;
  assign bus.dsp_reset = (dsp_reg == pwr_seq_pkg::DOM_SLEEP);
  assign bus.dsp_iso = (dsp_reg == pwr_seq_pkg::DOM_SLEEP);
  assign bus.dsp_idle = dsp_idle_reg;
  assign bus.host_state = host_reg;
  assign bus.dsp_state = dsp_reg;
  assign bus.chip_state = chip_reg;
endmodule
`default_nettype wire

// ===== pwr_seq_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwr_seq_cfg.svh"
module pwr_seq_host (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_por_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_standby,
  pwr_seq_if.host bus
);
  // ****************************************
  // APB registers
  // ****************************************
  logic [31:0] ctrl_reg;
  logic [31:0] dspctl_reg;
  logic iso_reg;
  logic standby_reg;
  logic wr_en, hit;

  assign wr_en = i_psel && i_penable && i_pwrite;
  assign hit = (i_paddr == `PSQ_CTRL_OFS) ||
               (i_paddr == `PSQ_DSPCTL_OFS) ||
               (i_paddr == `PSQ_STATUS_OFS);

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_reg <= `PSQ_CTRL_RST;
      dspctl_reg <= `PSQ_DSPCTL_RST;
      standby_reg <= 1'b0;
    end else begin
      standby_reg <= 1'b0;
      if (wr_en && i_paddr == `PSQ_CTRL_OFS) begin
        ctrl_reg <= i_pwdata;
        // Bit 31 issues the standby wait-for-interrupt
        standby_reg <= i_pwdata[31];
      end
      if (wr_en && i_paddr == `PSQ_DSPCTL_OFS)
        dspctl_reg <= i_pwdata;
    end
  end

  // Isolation survives all resets except power-up
  always_ff @(posedge i_clk_sys or negedge i_por_n) begin
    if (!i_por_n) begin
      iso_reg <= 1'b0;
    end else if (wr_en && i_paddr == `PSQ_CTRL_OFS) begin
      iso_reg <= i_pwdata[`PSQ_ISO_BIT];
    end
  end

  logic [31:0] rdata_next;
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (i_paddr)
      `PSQ_CTRL_OFS: begin
        rdata_next = {1'b0, ctrl_reg[30:0]};
        rdata_next[`PSQ_ISO_BIT] = iso_reg;
      end
      `PSQ_DSPCTL_OFS: rdata_next = dspctl_reg;
      `PSQ_STATUS_OFS: rdata_next = {16'h0000, 5'h00, bus.chip_state,
                                     2'b00, bus.dsp_state, bus.host_state,
                                     bus.low_voltage_request,
                                     bus.dsp_idle};
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // Captured in the setup cycle, so the word stands through the access
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prdata <= 32'h0000_0000;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      o_prdata <= rdata_next;
    end
  end
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !hit;

  // ****************************************
  // Drives toward the device
  // ****************************************
  assign bus.lv_en = ctrl_reg[`PSQ_LV_EN_BIT];
  assign bus.deep_en = ctrl_reg[`PSQ_DEEP_EN_BIT];
  assign bus.osc_ctl = ctrl_reg[`PSQ_OSC_CTL_BIT];
  assign bus.iso_ctl = iso_reg;
  assign bus.dsp_en = dspctl_reg[`PSQ_DSP_EN_BIT];
  assign bus.dsp_rst = dspctl_reg[`PSQ_DSP_RST_BIT];
  assign bus.dsp_input_clock_en = dspctl_reg[`PSQ_DSP_CKEN_BIT];
  // Supply follows bit 3 of the DSP control register
  assign bus.supply_on = dspctl_reg[`PSQ_SUPPLY_BIT];
  assign bus.host_standby = standby_reg;
  assign o_standby = standby_reg;
endmodule
`default_nettype wire

// ===== pwr_seq_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pwr_seq_checker (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [1:0] host_state,
  input wire logic [1:0] dsp_state,
  input wire logic [2:0] chip_state,
  input wire logic dsp_reset,
  input wire logic dsp_iso,
  input wire logic dsp_clk_on,
  input wire logic proc_clk_en,
  input wire logic chip_wake,
  input wire logic low_voltage_request,
  input wire logic lv_en,
  input wire logic dsp_idle
);
  // ****************
  // Legal state pairs
  // ****************
  // Zero marks a pair that has no chip state of its own
  function automatic logic [3:0] chip_of(input logic [3:0] hd);
    case (hd)
      4'h0: chip_of = 4'h9;
      4'h1: chip_of = 4'hA;
      4'h3: chip_of = 4'hB;
      4'h5: chip_of = 4'hC;
      4'h7: chip_of = 4'hD;
      4'hA: chip_of = 4'hE;
      4'hB: chip_of = 4'hF;
      4'hF: chip_of = 4'h8;
      default: chip_of = 4'h0;
    endcase
  endfunction

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  chip_map_a: assert property (
    chip_of({host_state, dsp_state}) != 4'h0 |->
    chip_of({host_state, dsp_state}) == {1'b1, chip_state})
    else $error("chip state does not match domain states");
  dsp_sleep_a: assert property (
    dsp_state == pwr_seq_pkg::DOM_SLEEP |->
    dsp_reset && dsp_iso && !dsp_clk_on)
    else $error("sleeping dsp not reset, isolated and stopped");
  dsp_run_a: assert property (
    dsp_state != pwr_seq_pkg::DOM_SLEEP |-> !dsp_reset && !dsp_iso)
    else $error("retaining dsp held in reset or isolation");
  dsp_gate_a: assert property (
    dsp_state inside {pwr_seq_pkg::DOM_INACTIVE,
    pwr_seq_pkg::DOM_PENDING} |-> !dsp_clk_on)
    else $error("dsp clock runs while idle");
  dsp_pend_a: assert property (
    $rose(dsp_state == pwr_seq_pkg::DOM_PENDING) |->
    $past(dsp_state) == pwr_seq_pkg::DOM_INACTIVE)
    else $error("dsp pending without being inactive");
  lv_on_a: assert property (
    $rose(host_state == pwr_seq_pkg::DOM_PENDING) && lv_en |->
    ##[1:2] low_voltage_request)
    else $error("low voltage request missing in deep sleep");
  lv_off_a: assert property (
    (host_state == pwr_seq_pkg::DOM_ACTIVE) [*3] |-> !low_voltage_request)
    else $error("low voltage request while awake");
  clk_off_a: assert property (
    (host_state != pwr_seq_pkg::DOM_ACTIVE) [*3] |-> !proc_clk_en)
    else $error("processor clock on while host idle");
  wake_flag_a: assert property (
    $fell(proc_clk_en) |-> ##[0:2] chip_wake)
    else $error("chip wake not raised at clock stop");
  idle_flag_a: assert property (
    $rose(dsp_state == pwr_seq_pkg::DOM_INACTIVE) &&
    $past(dsp_state) == pwr_seq_pkg::DOM_ACTIVE |-> ##[0:3] dsp_idle)
    else $error("dsp idle flag not set");
endmodule
`default_nettype wire

// ===== dual_domain_power_mode_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dual_domain_power_mode_sequencer_bench;
  typedef struct {logic [11:0] a; logic [31:0] d; logic e;} row_t;
  logic i_clk_sys, i_rst_n, i_por_n, psel, penable, pwrite, pready, pslverr;
  logic rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] ev;
  logic [3:0] ramp;
  int miscompares, checked, k;
  row_t rows [5] = '{'{12'h000, 32'h0, 1'b0}, '{12'h004, 32'h3, 1'b0},
    '{12'h008, 32'h330, 1'b0}, '{12'h00C, 32'h0, 1'b1},
    '{12'hFFC, 32'h0, 1'b1}};

  pwr_seq_if pwr_if();
  // Supply regulator: good only some cycles after switch-on
  always_ff @(posedge i_clk_sys) ramp <= {ramp[2:0], pwr_if.supply_on};
  assign pwr_if.pwr_good = ramp[3];
  assign pwr_if.host_irq = ev[0];
  assign pwr_if.dsp_irq = ev[1];
  assign pwr_if.ext_clk_req = ev[2];
  assign pwr_if.dsp_idle_exec = ev[3];

  pwr_seq_dev pwr_seq_dev_i (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_host_irq(pwr_if.host_irq), .i_dsp_irq(pwr_if.dsp_irq),
    .i_ext_clk_req(pwr_if.ext_clk_req),
    .i_dsp_idle_exec(pwr_if.dsp_idle_exec),
    .i_host_standby(pwr_if.host_standby), .bus(pwr_if));
  pwr_seq_host pwr_seq_host_i (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_por_n(i_por_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_standby(), .bus(pwr_if));
  pwr_seq_checker pwr_seq_checker_i (.i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n), .host_state(pwr_if.host_state),
    .dsp_state(pwr_if.dsp_state), .chip_state(pwr_if.chip_state),
    .dsp_reset(pwr_if.dsp_reset), .dsp_iso(pwr_if.dsp_iso),
    .dsp_clk_on(pwr_if.dsp_clk_on), .proc_clk_en(pwr_if.proc_clk_en),
    .chip_wake(pwr_if.chip_wake), .lv_en(pwr_if.lv_en),
    .low_voltage_request(pwr_if.low_voltage_request),
    .dsp_idle(pwr_if.dsp_idle));

  initial begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end

  // ****************
  // Shared tasks
  // ****************
  task automatic check(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Entered just after a rising edge; leaves one edge after the access
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk_sys);
    penable <= 1'b1;
    @(posedge i_clk_sys);
    while (pready !== 1'b1) @(posedge i_clk_sys);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_clk_sys);
  endtask

  // sel 0 waits on the chip state, sel 1 on the host domain state
  task automatic wait_for(input int sel, input logic [2:0] e);
    int n;
    n = 0;
    while ((sel ? {1'b0, pwr_if.host_state} : pwr_if.chip_state) !== e &&
      n < 300) begin
      @(posedge i_clk_sys);
      n++;
    end
    check("state", 32'(sel ? {1'b0, pwr_if.host_state} : pwr_if.chip_state),
      32'(e));
  endtask

  // Held well past the two synchroniser stages
  task automatic fire(input int i);
    ev[i] <= 1'b1;
    repeat (6) @(posedge i_clk_sys);
    ev[i] <= 1'b0;
    @(posedge i_clk_sys);
  endtask

  task automatic close_out;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge i_clk_sys);
    miscompares++;
    close_out();
  end

  // ****************
  // Main sequence
  // ****************
  initial begin
    {i_rst_n, i_por_n, psel, penable, pwrite, paddr, pwdata, ev} = '0;
    repeat (8) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    i_por_n <= 1'b1;
    @(posedge i_clk_sys);
    foreach (rows[j]) begin
      apb(1'b0, rows[j].a, 32'h0);
      check("pslverr", 32'(rerr), 32'(rows[j].e));
      if (!rows[j].e) check("rdata", rd, rows[j].d);
    end
    $display("test reset_regs done");
    apb(1'b1, 12'h004, 32'h0000_000B);
    repeat (8) @(posedge i_clk_sys);
    // Supply is good but software has not released the DSP yet
    fire(1);
    check("sleep_irq", 32'(pwr_if.chip_state), 32'h3);
    apb(1'b1, 12'h000, 32'h0000_0000);
    apb(1'b1, 12'h004, 32'h0000_000F);
    apb(1'b1, 12'h004, 32'h0000_000C);
    wait_for(0, 3'h1);
    check("dsp_reset", 32'(pwr_if.dsp_reset), 32'h0);
    fire(3);
    wait_for(0, 3'h2);
    apb(1'b0, 12'h008, 32'h0);
    check("dsp_idle", 32'(rd[0]), 32'h1);
    fire(1);
    wait_for(0, 3'h1);
    check("dsp_clk", 32'(pwr_if.dsp_clk_on), 32'h1);
    $display("test dsp_wake done");
    for (k = 0; k < 3; k++) begin
      fire(3);
      wait_for(0, 3'h2);
      apb(1'b1, 12'h000, 32'h8000_0000);
      wait_for(0, 3'h4);
      check("proc_clk", 32'(pwr_if.proc_clk_en), 32'h0);
      fire(k);
      wait_for(1, 3'h0);
    end
    $display("test big_sleep done");
    fire(3);
    wait_for(0, 3'h2);
    apb(1'b1, 12'h000, 32'h8000_0211);
    wait_for(0, 3'h6);
    // Both pin outputs are registered one edge after entry
    repeat (2) @(posedge i_clk_sys);
    check("low_v", 32'(pwr_if.low_voltage_request), 32'h1);
    check("osc_stop", 32'(pwr_if.osc_stop), 32'h1);
    fire(1);
    wait_for(1, 3'h0);
    check("low_v", 32'(pwr_if.low_voltage_request), 32'h0);
    $display("test deep_sleep done");
    fire(3);
    wait_for(0, 3'h2);
    apb(1'b1, 12'h004, 32'h0000_000F);
    apb(1'b1, 12'h004, 32'h0000_000B);
    apb(1'b1, 12'h000, 32'h0000_1000);
    apb(1'b1, 12'h004, 32'h0000_0003);
    wait_for(0, 3'h3);
    check("dsp_iso", 32'(pwr_if.dsp_iso), 32'h1);
    fire(1);
    repeat (10) @(posedge i_clk_sys);
    check("no_wake", 32'(pwr_if.chip_state), 32'h3);
    $display("test dsp_sleep done");
    // Warm reset must leave the isolation bit alone
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    @(posedge i_clk_sys);
    apb(1'b0, 12'h000, 32'h0);
    check("iso_warm", rd, 32'h0000_1000);
    i_por_n <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_por_n <= 1'b1;
    @(posedge i_clk_sys);
    apb(1'b0, 12'h000, 32'h0);
    check("iso_por", rd, 32'h0000_0000);
    $display("test iso_reset done");
    close_out();
  end
endmodule
`default_nettype wire
